// ==== src/plscfg_decode.sv ====
// combinational decoder of one loop-setting field by operating mode
`timescale 1ns/1ps
module plscfg_decode
    import plscfg_pkg::*;
(
    // field and mode
    input  wire logic [LS_W-1:0] loop_settings_i,
    input  wire plscfg_mode_t    mode_i,
    // decoded result
    output plscfg_loop_t         loop_o
);

    always_comb begin
        loop_o = LOOP_RESET;
        loop_o.upper_pump_reduce = loop_settings_i[LS_RED_BIT];
        if (mode_i == PLSCFG_MODE_LOWBW) begin
            loop_o.upper_loop_filter  = FILTER_FORCED;
            loop_o.upper_pump_current = PUMP_FORCED;
            loop_o.converter_gain     = loop_settings_i[LS_GAIN_HI:LS_GAIN_LO];
            loop_o.lower_pump_current = loop_settings_i[LS_PUMP_HI:LS_PUMP_LO];
            loop_o.lower_loop_active  = 1'h1;
            // modulator bits are gain bits here, so order and enable stay low
        end else begin
            loop_o.upper_loop_filter  = loop_settings_i[LS_ULF_HI:LS_ULF_LO];
            loop_o.modulator_order    = loop_settings_i[LS_ORD_BIT];
            loop_o.modulator_enable   = loop_settings_i[LS_MEN_BIT];
            loop_o.upper_pump_current = loop_settings_i[LS_PUMP_HI:LS_PUMP_LO];
            // reserved pump code is passed on but flagged for software
            loop_o.pump_code_rsvd     = (loop_settings_i[LS_PUMP_HI:LS_PUMP_LO]
                                         == PUMP_RSVD);
        end
    end

endmodule // plscfg_decode

// ==== src/plscfg_pkg.sv ====
// package: types and constants for the status and loop-setting block
package plscfg_pkg;

    // operating mode codes
    typedef enum logic [1:0] {
        PLSCFG_MODE_LOWBW = 2'b00,
        PLSCFG_MODE_SYNTH = 2'b01,
        PLSCFG_MODE_HIBW  = 2'b10,
        PLSCFG_MODE_HIBW2 = 2'b11
    } plscfg_mode_t;

    // loop-setting field layout
    localparam int LS_W          = 7;
    localparam int LS_ULF_HI     = 6;
    localparam int LS_ULF_LO     = 5;
    localparam int LS_ORD_BIT    = 4;
    localparam int LS_MEN_BIT    = 3;
    localparam int LS_GAIN_HI    = 6;
    localparam int LS_GAIN_LO    = 3;
    localparam int LS_PUMP_HI    = 2;
    localparam int LS_PUMP_LO    = 1;
    localparam int LS_RED_BIT    = 0;

    // reset, forced and reserved values
    localparam logic [LS_W-1:0] LS_RESET      = 7'h00;
    localparam logic [1:0]      FILTER_FORCED = 2'h0;
    localparam logic [1:0]      PUMP_FORCED   = 2'h0;
    localparam logic [1:0]      PUMP_RSVD     = 2'h3;
    localparam logic [3:0]      GAIN_RESET    = 4'h0;

    // raw condition inputs from the analogue monitors
    typedef struct packed {
        logic input_a_fault;
        logic input_b_fault;
        logic crystal_fault;
        logic loop_locked;
        logic freeze_state;
        logic active_input;
    } plscfg_status_t;

    localparam plscfg_status_t STATUS_RESET = '{default: 1'h0};

    // decoded loop controls
    typedef struct packed {
        logic [1:0] upper_loop_filter;
        logic       modulator_order;
        logic       modulator_enable;
        logic [1:0] upper_pump_current;
        logic       upper_pump_reduce;
        logic [3:0] converter_gain;
        logic [1:0] lower_pump_current;
        logic       lower_loop_active;
        logic       pump_code_rsvd;
    } plscfg_loop_t;

    localparam plscfg_loop_t LOOP_RESET = '{default: 1'h0};

endpackage

// ==== src/plscfg_top.sv ====
// status flags, pin mirrors and per-configuration loop-setting decode
`timescale 1ns/1ps
module plscfg_top
    import plscfg_pkg::*;
(
    // clock and reset
    input  wire logic            clk_i,
    input  wire logic            resetn_i,
    // live conditions from monitors
    input  wire plscfg_status_t  cond_i,
    // host configuration
    input  wire logic [1:0]      mode_sel_i,
    input  wire logic            cfg_sel_i,
    input  wire logic            ls0_we_i,
    input  wire logic [LS_W-1:0] ls0_wdata_i,
    input  wire logic            ls1_we_i,
    input  wire logic [LS_W-1:0] ls1_wdata_i,
    // status register view and pin mirrors
    output plscfg_status_t       status_o,
    output logic                 input_a_fault_pin_o,
    output logic                 input_b_fault_pin_o,
    output logic                 crystal_fault_pin_o,
    output logic                 loop_locked_pin_o,
    output logic                 freeze_state_pin_o,
    output logic                 active_input_pin_o,
    // stored fields and decoded loop controls
    output logic [LS_W-1:0]      ls0_o,
    output logic [LS_W-1:0]      ls1_o,
    output plscfg_mode_t         mode_o,
    output plscfg_loop_t         loop_o,
    output logic                 osc_hold_o
);

    plscfg_status_t  status_d;
    plscfg_status_t  status_q;
    logic [LS_W-1:0] ls0_d;
    logic [LS_W-1:0] ls0_q;
    logic [LS_W-1:0] ls1_d;
    logic [LS_W-1:0] ls1_q;
    plscfg_mode_t    mode_d;
    plscfg_mode_t    mode_q;
    logic            cfg_d;
    logic            cfg_q;
    plscfg_loop_t    loop_d;
    plscfg_loop_t    loop_q;
    logic            hold_d;
    logic            hold_q;
    logic [LS_W-1:0] ls_active;
    plscfg_loop_t    loop_dec;

    // status: no host write path exists, so flags cannot be forced by software
    always_comb begin
        status_d = cond_i;
    end

    // configuration storage
    always_comb begin
        ls0_d = ls0_q;
        ls1_d = ls1_q;
        if (ls0_we_i) begin
            ls0_d = ls0_wdata_i;
        end
        if (ls1_we_i) begin
            ls1_d = ls1_wdata_i;
        end
        cfg_d  = cfg_sel_i;
        mode_d = plscfg_mode_t'(mode_sel_i);
    end

    // active field picked from the registered selection, one stage behind pins
    assign ls_active = cfg_q ? ls1_q : ls0_q;

    plscfg_decode u_decode (
        .loop_settings_i (ls_active),
        .mode_i          (mode_q),
        .loop_o          (loop_dec)
    );

    always_comb begin
        loop_d = loop_dec;
        hold_d = status_q.freeze_state;
    end

    // status group registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // configuration group registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ls0_q  <= LS_RESET;
            ls1_q  <= LS_RESET;
            mode_q <= PLSCFG_MODE_LOWBW;
            cfg_q  <= 1'h0;
        end else begin
            ls0_q  <= ls0_d;
            ls1_q  <= ls1_d;
            mode_q <= mode_d;
            cfg_q  <= cfg_d;
        end
    end

    // decoded controls and oscillator hold registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            loop_q <= LOOP_RESET;
            hold_q <= 1'h0;
        end else begin
            loop_q <= loop_d;
            hold_q <= hold_d;
        end
    end

    // pins and status bits come from the same flop so they never disagree
    assign status_o            = status_q;
    assign input_a_fault_pin_o = status_q.input_a_fault;
    assign input_b_fault_pin_o = status_q.input_b_fault;
    assign crystal_fault_pin_o = status_q.crystal_fault;
    assign loop_locked_pin_o   = status_q.loop_locked;
    assign freeze_state_pin_o  = status_q.freeze_state;
    assign active_input_pin_o  = status_q.active_input;
    assign ls0_o               = ls0_q;
    assign ls1_o               = ls1_q;
    assign mode_o              = mode_q;
    assign loop_o              = loop_q;
    assign osc_hold_o          = hold_q;

endmodule // plscfg_top

// ==== verif/plscfg_assertions.sv ====
// checker: port-level properties of the status and loop-setting block
`timescale 1ns/1ps
module plscfg_assertions
    import plscfg_pkg::*;
(
    input wire logic            clk_i,
    input wire logic            resetn_i,
    input wire plscfg_status_t  cond_i,
    input wire logic [1:0]      mode_sel_i,
    input wire logic            ls0_we_i,
    input wire logic [LS_W-1:0] ls0_wdata_i,
    input wire plscfg_status_t  status_o,
    input wire logic            input_a_fault_pin_o,
    input wire logic            input_b_fault_pin_o,
    input wire logic            crystal_fault_pin_o,
    input wire logic            loop_locked_pin_o,
    input wire logic            freeze_state_pin_o,
    input wire logic            active_input_pin_o,
    input wire logic [LS_W-1:0] ls0_o,
    input wire plscfg_mode_t    mode_o,
    input wire plscfg_loop_t    loop_o,
    input wire logic            osc_hold_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // decoded controls lag the registered mode by one edge
    sequence s_low; resetn_i && mode_o == PLSCFG_MODE_LOWBW ##1 1'b1; endsequence
    sequence s_high; resetn_i && mode_o != PLSCFG_MODE_LOWBW ##1 1'b1; endsequence
    AST_STATUS: assert property ($past(resetn_i) |-> status_o == $past(cond_i))
        else $error("status view lost the live condition");
    AST_PINS: assert property (
        {input_a_fault_pin_o, input_b_fault_pin_o, crystal_fault_pin_o, loop_locked_pin_o,
        active_input_pin_o} == {status_o[5:2], status_o[0]})
        else $error("pin mirror differs from status");
    AST_HOLD: assert property (
        $past(resetn_i) |-> osc_hold_o == $past(status_o.freeze_state)
        && freeze_state_pin_o == status_o.freeze_state)
        else $error("oscillator hold wrong");
    AST_MODE: assert property ($past(resetn_i) |-> mode_o == $past(mode_sel_i))
        else $error("mode not taken");
    AST_WRITE: assert property ($past(ls0_we_i) |-> ls0_o == $past(ls0_wdata_i))
        else $error("field write lost");
    AST_LOW: assert property (
        s_low |-> loop_o.upper_loop_filter == FILTER_FORCED
        && loop_o.upper_pump_current == PUMP_FORCED && loop_o.lower_loop_active)
        else $error("low mode forcing wrong");
    AST_HIGH: assert property (
        s_high |-> !loop_o.lower_loop_active && loop_o.converter_gain == GAIN_RESET)
        else $error("lower loop used outside low mode");
    AST_RSVD: assert property (
        loop_o.pump_code_rsvd == (loop_o.upper_pump_current == PUMP_RSVD))
        else $error("reserved pump flag wrong");
endmodule // plscfg_assertions

bind plscfg_top plscfg_assertions plscfg_assertions_i (
    .clk_i               (clk_i),
    .resetn_i            (resetn_i),
    .cond_i              (cond_i),
    .mode_sel_i          (mode_sel_i),
    .ls0_we_i            (ls0_we_i),
    .ls0_wdata_i         (ls0_wdata_i),
    .status_o            (status_o),
    .input_a_fault_pin_o (input_a_fault_pin_o),
    .input_b_fault_pin_o (input_b_fault_pin_o),
    .crystal_fault_pin_o (crystal_fault_pin_o),
    .loop_locked_pin_o   (loop_locked_pin_o),
    .freeze_state_pin_o  (freeze_state_pin_o),
    .active_input_pin_o  (active_input_pin_o),
    .ls0_o               (ls0_o),
    .mode_o              (mode_o),
    .loop_o              (loop_o),
    .osc_hold_o          (osc_hold_o)
);

// ==== verif/plscfg_far_model.sv ====
// far-side model: condition monitors feeding the live status inputs
`timescale 1ns/1ps
module plscfg_far_model
    import plscfg_pkg::*;
(
    input  wire logic           clk_i,
    input  wire logic           rnd_i,
    input  wire plscfg_status_t fix_i,
    output plscfg_status_t      cond_o
);
    int seed = 23;
    initial cond_o = STATUS_RESET;
    // random levels change every cycle so a stale copy shows at once
    always @(posedge clk_i) cond_o <= rnd_i ? 6'($random(seed)) : fix_i;
endmodule // plscfg_far_model

// ==== verif/tb_plscfg_top.sv ====
// testbench: random and corner stimulus with self-checking comparisons
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; \
    $display("FAIL %s exp %h got %h", n, e, a); end end
module tb_plscfg_top;
    import plscfg_pkg::*;
    logic clk_i = 0, resetn_i = 0, rnd = 0, cfg = 0, we0 = 0, we1 = 0, hold;
    logic [1:0] mode = 0;
    logic [6:0] d0 = 0, d1 = 0, q0, q1;
    plscfg_status_t fix = '0, cond, cond_q, st;
    plscfg_mode_t mo;
    plscfg_loop_t lp;
    int seed = 23, fail_count = 0, checked = 0;
    plscfg_far_model plscfg_far_model_i (.clk_i(clk_i), .rnd_i(rnd), .fix_i(fix), .cond_o(cond));
    plscfg_top plscfg_top_i (.clk_i(clk_i), .resetn_i(resetn_i), .cond_i(cond), .mode_sel_i(mode),
        .cfg_sel_i(cfg), .ls0_we_i(we0), .ls0_wdata_i(d0), .ls1_we_i(we1), .ls1_wdata_i(d1),
        .status_o(st), .input_a_fault_pin_o(), .input_b_fault_pin_o(), .crystal_fault_pin_o(),
        .loop_locked_pin_o(), .freeze_state_pin_o(), .active_input_pin_o(), .ls0_o(q0),
        .ls1_o(q1), .mode_o(mo), .loop_o(lp), .osc_hold_o(hold));
    initial forever #4 clk_i = ~clk_i;
    always @(posedge clk_i) cond_q <= cond;
    always @(negedge clk_i) if (rnd) `CHK("status", cond_q, st)
    function automatic plscfg_loop_t dec(input logic [6:0] v, input logic [1:0] m);
        dec = '0;
        dec.upper_pump_reduce = v[0];
        if (m == 2'h0) begin
            dec.converter_gain = v[6:3];
            dec.lower_pump_current = v[2:1];
            dec.lower_loop_active = 1'h1;
        end else begin
            dec.upper_loop_filter = v[6:5];
            dec.modulator_order = v[4];
            dec.modulator_enable = v[3];
            dec.upper_pump_current = v[2:1];
            dec.pump_code_rsvd = v[2:1] == 2'h3;
        end
    endfunction
    // host never programs the reserved pump code in random traffic
    function automatic logic [6:0] rv();
        rv = 7'($random(seed));
        if (rv[2:1] == 2'h3) rv[2] = 1'h0;
    endfunction
    task automatic cfg_run(input logic [6:0] a, b, input logic [1:0] m, input logic c);
        @(posedge clk_i) {we0, we1, d0, d1, mode, cfg} <= {2'h3, a, b, m, c};
        @(posedge clk_i) {we0, we1} <= 2'h0;
        repeat (4) @(negedge clk_i);
        `CHK("ls0", a, q0)
        `CHK("ls1", b, q1)
        `CHK("mode", m, mo)
        `CHK("loop", dec(c ? b : a, m), lp)
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #(8 * 4000);
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'h1;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_i) fix <= i[0] ? 6'h0 : 6'h1 << (i / 2);
            repeat (4) @(negedge clk_i);
            `CHK("flags", fix, st)
            `CHK("hold", fix.freeze_state, hold)
        end
        $display("test flags done");
        @(posedge clk_i) rnd <= 1'h1;
        repeat (40) @(posedge clk_i);
        rnd <= 1'h0;
        $display("test random status done");
        for (int m = 0; m < 4; m++)
            for (int c = 0; c < 2; c++) begin
                cfg_run(7'h7f, 7'h06, m[1:0], c[0]);
                cfg_run(rv(), rv(), m[1:0], c[0]);
            end
        $display("test decode done");
        print_verdict();
    end
endmodule // tb_plscfg_top
